//--- design/tbc_top.sv
// Summary of operation
// - Bit 13 selects reduced receive threshold.
// - Squelch code sets 200mV plus 50mV steps.
// - Bit 7 stops normal link pulse transmission.
// - Bit 4 mirrors the receive polarity flag.
// - Reading line control clears both polarity copies.
// - Bit 0 disables jabber, only at 10 Mbps.
// - Count bytes the PRBS checker finds errored.
// - Gap field sets gap in four-byte units.
`timescale 1ns/1ns
`include "tbc_map.svh"
module tbc_top
  import tbc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire tbc_addr_type reg_addr,
  input wire tbc_word_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output tbc_word_type reg_rdata,
  input wire logic rx_pol_inverted,
  input wire logic prbs_byte_error,
  input wire logic err_cnt_mode_wrap,
  input wire logic speed_10,
  output logic rx_low_threshold,
  output logic [3:0] squelch_code,
  output tbc_mv_type squelch_mv,
  output logic link_pulse_tx_off,
  output logic jabber_enable,
  output logic phy_summary_polarity,
  output logic [7:0] selftest_gap_length,
  output logic [9:0] selftest_gap_bytes
);
  logic jabber_off;
  logic pol_flag;
  logic [CNT_W-1:0] err_count_latched;
  tbc_word_type next_rdata;

  wire line_sel = reg_addr == `TBC_LINE_CTRL_ADDR;
  wire test_sel = reg_addr == `TBC_SELFTEST_ADDR;
  wire line_wr = reg_wr && line_sel;
  wire test_wr = reg_wr && test_sel;
  wire line_rd = reg_rd && line_sel;
  wire lock_wr = test_wr && reg_wdata[`TBC_LOCK_BIT];
  wire next_pol = rx_pol_inverted || (pol_flag && !line_rd);

  tbc_err_if #(.CNT_W(CNT_W)) err_bus ();

  assign err_bus.byte_err = prbs_byte_error;
  assign err_bus.clear = lock_wr;
  assign err_bus.saturate = !err_cnt_mode_wrap;

  tbc_err_counter #(.CNT_W(CNT_W)) u_err_counter (
    .clk(clk),
    .rstn(rstn),
    .err(err_bus)
  );

  wire tbc_word_type line_word = {
    2'h0,
    rx_low_threshold,
    squelch_code,
    1'b0,
    link_pulse_tx_off,
    2'h0,
    pol_flag,
    3'h0,
    jabber_off
  };

  wire tbc_word_type test_word = {err_count_latched, selftest_gap_length};

  assign next_rdata = line_sel ? line_word :
                      test_sel ? test_word : 16'h0000;

  // Control fields of the line register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_low_threshold <= 1'(`TBC_LINE_CTRL_RESET >> `TBC_LOW_THR_BIT);
      squelch_code <= 4'h0;
      squelch_mv <= `TBC_SQUELCH_BASE_MV;
      link_pulse_tx_off <= 1'b0;
      jabber_off <= 1'b0;
    end else if (line_wr) begin
      rx_low_threshold <= reg_wdata[`TBC_LOW_THR_BIT];
      squelch_code <= reg_wdata[`TBC_SQUELCH_MSB:`TBC_SQUELCH_LSB];
      squelch_mv <= tbc_squelch_mv(reg_wdata[`TBC_SQUELCH_MSB:`TBC_SQUELCH_LSB]);
      link_pulse_tx_off <= reg_wdata[`TBC_LINK_PULSE_OFF_BIT];
      jabber_off <= reg_wdata[`TBC_JABBER_OFF_BIT];
    end
  end

  // Jabber only exists on the 10 Mbps path; at 100 Mbps the output stays low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      jabber_enable <= 1'b0;
    end else begin
      jabber_enable <= speed_10 && !jabber_off;
    end
  end

  // One flag serves both views, so the status copy can never disagree with bit 4.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pol_flag <= 1'b0;
    end else begin
      pol_flag <= next_pol;
    end
  end

  assign phy_summary_polarity = pol_flag;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selftest_gap_length <= `TBC_GAP_RESET;
      err_count_latched <= '0;
    end else if (test_wr) begin
      selftest_gap_length <= reg_wdata[`TBC_GAP_MSB:`TBC_GAP_LSB];
      if (lock_wr) begin
        err_count_latched <= err_bus.count;
      end
    end
  end

  assign selftest_gap_bytes = {selftest_gap_length, 2'b00};

  // Read data is captured before the read's clearing effect lands.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_low_thr;
    line_wr |=> rx_low_threshold == $past(reg_wdata[`TBC_LOW_THR_BIT]);
  endproperty
  a_low_thr: assert property (p_low_thr) else $error("threshold bit not applied");

  property p_squelch;
    line_wr && reg_wdata[`TBC_SQUELCH_MSB:`TBC_SQUELCH_LSB] <= 4'h8
      |=> squelch_mv == 10'h0c8 + 10'h032 * {6'h00, $past(reg_wdata[12:9])};
  endproperty
  a_squelch: assert property (p_squelch) else $error("squelch threshold wrong");

  property p_link_pulse;
    line_wr ##1 !line_wr |-> link_pulse_tx_off == $past(reg_wdata[`TBC_LINK_PULSE_OFF_BIT]);
  endproperty
  a_link_pulse: assert property (p_link_pulse) else $error("link pulse control wrong");

  property p_pol_set;
    rx_pol_inverted |=> pol_flag && phy_summary_polarity;
  endproperty
  a_pol_set: assert property (p_pol_set) else $error("polarity event lost");

  property p_pol_read;
    line_rd |=> reg_rdata[`TBC_POLARITY_BIT] == $past(pol_flag);
  endproperty
  a_pol_read: assert property (p_pol_read) else $error("polarity bit misread");

  property p_pol_clear;
    line_rd && !rx_pol_inverted |=> !pol_flag;
  endproperty
  a_pol_clear: assert property (p_pol_clear) else $error("polarity not cleared");

  property p_pol_keep;
    pol_flag && !line_rd |=> pol_flag;
  endproperty
  a_pol_keep: assert property (p_pol_keep) else $error("polarity dropped");

  property p_jabber;
    line_wr && reg_wdata[0] |=> ##1 !jabber_enable;
  endproperty
  a_jabber: assert property (p_jabber) else $error("jabber not disabled");

  property p_jabber_speed;
    !speed_10 |=> !jabber_enable;
  endproperty
  a_jabber_speed: assert property (p_jabber_speed) else $error("jabber at 100M");

  property p_lock;
    lock_wr |=> err_count_latched == $past(err_bus.count);
  endproperty
  a_lock: assert property (p_lock) else $error("count not latched");

  property p_gap;
    test_wr |=> selftest_gap_bytes == {$past(reg_wdata[7:0]), 2'b00};
  endproperty
  a_gap: assert property (p_gap) else $error("gap length wrong");

  property p_reserved;
    line_rd |=> reg_rdata[15:14] == 2'h0 && !reg_rdata[8] && reg_rdata[6:5] == 2'h0
      && reg_rdata[3:1] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_unmapped;
    reg_rd && !line_sel && !test_sel |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
endmodule

//--- inc/tbc_map.svh
`ifndef TBC_MAP_SVH
`define TBC_MAP_SVH
`define TBC_LINE_CTRL_ADDR 5'h1a
`define TBC_SELFTEST_ADDR 5'h1b
`define TBC_LINE_CTRL_RESET 16'h0000
`define TBC_SELFTEST_RESET 16'h007d
`define TBC_LINE_CTRL_RW_MASK 16'h3e81
`define TBC_LOW_THR_BIT 13
`define TBC_SQUELCH_MSB 12
`define TBC_SQUELCH_LSB 9
`define TBC_LINK_PULSE_OFF_BIT 7
`define TBC_POLARITY_BIT 4
`define TBC_JABBER_OFF_BIT 0
`define TBC_LOCK_BIT 15
`define TBC_COUNT_MSB 15
`define TBC_COUNT_LSB 8
`define TBC_GAP_MSB 7
`define TBC_GAP_LSB 0
`define TBC_GAP_RESET 8'h7d
`define TBC_SQUELCH_BASE_MV 10'h0c8
`define TBC_SQUELCH_STEP_MV 10'h032
`define TBC_SQUELCH_MAX_CODE 4'h8
`endif

//--- inc/tbc_pkg.sv
`include "tbc_map.svh"
package tbc_pkg;
  typedef logic [15:0] tbc_word_type;
  typedef logic [4:0] tbc_addr_type;
  typedef logic [9:0] tbc_mv_type;

  // Codes above the top step keep the highest threshold rather than wrap.
  function automatic tbc_mv_type tbc_squelch_mv(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `TBC_SQUELCH_MAX_CODE) ? `TBC_SQUELCH_MAX_CODE : code;
    return `TBC_SQUELCH_BASE_MV + `TBC_SQUELCH_STEP_MV * {6'h00, c};
  endfunction
endpackage

//--- inc/tbc_err_if.sv
`timescale 1ns/1ns
interface tbc_err_if #(
  parameter int CNT_W = 8
);
  logic byte_err;
  logic clear;
  logic saturate;
  logic [CNT_W-1:0] count;
  modport counter (
    input byte_err,
    input clear,
    input saturate,
    output count
  );
  modport owner (
    output byte_err,
    output clear,
    output saturate,
    input count
  );
endinterface

//--- design/tbc_err_counter.sv
`timescale 1ns/1ns
module tbc_err_counter #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  tbc_err_if.counter err
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  wire full = &count;
  wire hold = full && err.saturate;

  // A byte error in the clearing cycle is counted, so the count restarts at one.
  assign next_count = err.clear ? CNT_W'(err.byte_err) :
                      (err.byte_err && !hold) ? count + CNT_W'(1) : count;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign err.count = count;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_count_up;
    err.byte_err && !err.clear && !full |=> count == $past(count) + CNT_W'(1);
  endproperty
  a_count_up: assert property (p_count_up) else $error("error byte not counted");

  property p_saturate;
    err.saturate && full && !err.clear |=> full;
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter left saturation");

  property p_clear;
    err.clear |=> count == CNT_W'($past(err.byte_err));
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared");

  property p_idle;
    !err.byte_err && !err.clear |=> $stable(count);
  endproperty
  a_idle: assert property (p_idle) else $error("counter moved without cause");
endmodule

//--- test/tbc_host.sv
`timescale 1ns/1ns
module tbc_host
  import tbc_pkg::*;
(
  input wire logic clk,
  input wire tbc_word_type rdata,
  output tbc_addr_type addr,
  output tbc_word_type wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Write data is inverted once the strobe drops so stale values never look valid.
  task automatic write(input tbc_addr_type a, input tbc_word_type d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d;
  endtask
  task automatic read(input tbc_addr_type a, output tbc_word_type d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic lock_read(input logic [7:0] gap, output tbc_word_type d);
    write(5'h1b, {8'h80, gap});
    read(5'h1b, d);
  endtask
endmodule

//--- test/tbc_top_test.sv
`timescale 1ns/1ns
module tbc_top_test;
  import tbc_pkg::*;
  logic clk, rstn, pol, err, wrap, spd, wr, rd, low_thr, lp_off, jab_en, phy_pol;
  tbc_addr_type addr;
  tbc_word_type wdata, rdata, d;
  logic [3:0] sq;
  tbc_mv_type mv;
  logic [7:0] gap;
  logic [9:0] gap_b;
  int miscompares, n_tests, cyc;
  tbc_host i_tbc_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  tbc_top i_tbc_top (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .rx_pol_inverted(pol),
    .prbs_byte_error(err), .err_cnt_mode_wrap(wrap), .speed_10(spd),
    .rx_low_threshold(low_thr), .squelch_code(sq), .squelch_mv(mv),
    .link_pulse_tx_off(lp_off), .jabber_enable(jab_en), .phy_summary_polarity(phy_pol),
    .selftest_gap_length(gap), .selftest_gap_bytes(gap_b));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Holding the error strobe for n cycles counts n bytes.
  task automatic errs(input int n);
    @(negedge clk);
    err = 1'b1;
    repeat (n) @(negedge clk);
    err = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    rstn = 1'b0;
    {pol, err, wrap} = 3'h0;
    spd = 1'b1;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    chk(mv, 16'h00c8);
    chk(gap_b, 16'h01f4);
    i_tbc_host.read(5'h1a, d);
    chk(d, 16'h0000);
    i_tbc_host.read(5'h1b, d);
    chk(d, 16'h007d);
    i_tbc_host.write(5'h1a, 16'hffff);
    i_tbc_host.read(5'h1a, d);
    chk(d, 16'h3e81);
    chk({low_thr, lp_off, jab_en}, 16'h0006);
    chk(mv, 16'h0258);
    for (int c = 0; c < 9; c++) begin
      i_tbc_host.write(5'h1a, 16'(c) << 9);
      @(negedge clk);
      chk(mv, 16'h00c8 + 16'h0032 * 16'(c));
      chk(sq, 16'(c));
      chk({low_thr, lp_off, jab_en}, 16'h0001);
    end
    spd = 1'b0;
    repeat (2) @(negedge clk);
    chk(jab_en, 16'h0000);
    pol = 1'b1;
    @(negedge clk);
    pol = 1'b0;
    chk(phy_pol, 16'h0001);
    i_tbc_host.read(5'h1b, d);
    chk(phy_pol, 16'h0001);
    i_tbc_host.read(5'h1a, d);
    chk(d, 16'h1010);
    chk(phy_pol, 16'h0000);
    i_tbc_host.read(5'h1a, d);
    chk(d, 16'h1000);
    // A polarity event in the reading cycle must survive the read-clear.
    pol = 1'b1;
    i_tbc_host.read(5'h1a, d);
    pol = 1'b0;
    chk(d, 16'h1010);
    chk(phy_pol, 16'h0001);
    i_tbc_host.read(5'h1a, d);
    chk(d, 16'h1010);
    chk(phy_pol, 16'h0000);
    errs(5);
    i_tbc_host.lock_read(8'h12, d);
    chk(d, 16'h0512);
    chk(gap_b, 16'h0048);
    chk(gap, 16'h0012);
    errs(300);
    i_tbc_host.lock_read(8'h12, d);
    chk(d, 16'hff12);
    errs(3);
    i_tbc_host.write(5'h1b, 16'h0034);
    i_tbc_host.read(5'h1b, d);
    chk(d, 16'hff34);
    wrap = 1'b1;
    errs(297);
    i_tbc_host.lock_read(8'h7d, d);
    chk(d, 16'h2c7d);
    i_tbc_host.write(5'h05, 16'hffff);
    i_tbc_host.read(5'h05, d);
    chk(d, 16'h0000);
    i_tbc_host.read(5'h1a, d);
    chk(d, 16'h1000);
    // Errored bytes before and in the lock cycle: the earlier one is latched away, the lock-cycle one restarts the count.
    err = 1'b1;
    i_tbc_host.write(5'h1b, 16'h807d);
    err = 1'b0;
    i_tbc_host.read(5'h1b, d);
    chk(d, 16'h017d);
    i_tbc_host.lock_read(8'h7d, d);
    chk(d, 16'h017d);
    end_of_test();
  end
endmodule
